// *** pkg/tdl_cfg.svh ***
// What this block does
// (R1) Suspend averaging when ticks exceed averaging limit
// (R2) Three saturated sensors at once start compensation
// (R3) Large negative ticks start an offset compensation
// (R4) Negative counter past maximum triggers compensation; code fires on the scan where the count reaches maximum
// (R5) Negative count code zero reserved, default one
// (R6) Touch above threshold plus shared hysteresis percent
// (R7) Release below threshold minus hysteresis percent
// (R8) Held touch past timeout reported released
// (R9) Timeout zero disables forced release, default
// (R10) Wheel release debounce: immediate, 2, 3, 4
// (R11) Wheel touch debounce: immediate, 2, 3, 4
// (R12) Wheel norm sixteen bits, reset 0x0140
// (R13) Rotation limit is percent of maximum position
// (R14) Debounce counts scan samples before deciding
// (R15) Wheel released at zero pressure, touched above hysteresis
// (R16) Rotation flagged only when step exceeds limit
// (R17) Forced-release timer counts seconds, restarts per touch
`ifndef TDL_CFG_SVH
`define TDL_CFG_SVH
`define TDL_OFS_BTN_DEB      8'h21
`define TDL_OFS_BTN_AVG      8'h22
`define TDL_OFS_BTN_NEG      8'h23
`define TDL_OFS_BTN_NCNT     8'h24
`define TDL_OFS_BTN_HYST     8'h25
`define TDL_OFS_BTN_STUCK    8'h26
`define TDL_OFS_WHL_DEB      8'h27
`define TDL_OFS_WHL_STUCK    8'h28
`define TDL_OFS_WHL_HYST     8'h29
`define TDL_OFS_WHL_NORM_HI  8'h2b
`define TDL_OFS_WHL_NORM_LO  8'h2c
`define TDL_OFS_WHL_AVG      8'h2d
`define TDL_OFS_WHL_NEG      8'h2e
`define TDL_OFS_WHL_NCNT     8'h2f
`define TDL_OFS_WHL_ROT      8'h30
`define TDL_OFS_STATUS       8'h3f
`define TDL_RST_DEB          8'h00
`define TDL_RST_STUCK        8'h00
`define TDL_RST_AVG          8'h50
`define TDL_RST_NEG          8'h50
`define TDL_RST_NCNT         8'h01
`define TDL_RST_BTN_HYST     8'h0a
`define TDL_RST_WHL_HYST     8'h03
`define TDL_RST_NORM         16'h0140
`define TDL_RST_ROT          8'h02
`define TDL_LIMIT_SHIFT      2
`define TDL_NORM_SHIFT       5
`define TDL_PERCENT          27'sd100
`define TDL_SAT_SENSORS      3
`define TDL_CLK_PERIOD_NS    25
`define TDL_ONE_SECOND_NS    1000000000
`define TDL_SEC_CYCLES       (`TDL_ONE_SECOND_NS / `TDL_CLK_PERIOD_NS)
`endif

// *** pkg/tdl_pkg.sv ***
package tdl_pkg;
  typedef struct packed {
    logic [3:0] rsvd;
    logic [1:0] rel_deb;
    logic [1:0] touch_deb;
  } tdl_deb_cfg_s;

  typedef enum logic [1:0] {
    TDL_IDLE,
    TDL_TOUCHED,
    TDL_STUCK
  } tdl_state_e;
endpackage

// *** src/tdl_decider.sv ***
`timescale 1ns/1ps
`include "tdl_cfg.svh"
module tdl_decider
  import tdl_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         scan_en_i,
  input  wire logic         sec_tick_i,
  input  wire logic         touch_cond_i,
  input  wire logic         release_cond_i,
  input  wire tdl_deb_cfg_s deb_cfg_i,
  input  wire logic [7:0]   timeout_i,
  output logic              touched_o
);
  tdl_state_e state_r;
  logic [1:0] cnt_r;
  logic [7:0] secs_r;
  logic       tdone;
  logic       rdone;

  // code 00 means one sample, so need = code + 1
  assign tdone = (cnt_r >= deb_cfg_i.touch_deb); // R11 R14
  assign rdone = (cnt_r >= deb_cfg_i.rel_deb);   // R10 R14

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= TDL_IDLE;
      cnt_r   <= 2'h0;
      secs_r  <= 8'h00;
    end else begin
      case (state_r)
        TDL_IDLE: begin
          if (scan_en_i) begin
            if (touch_cond_i && tdone) begin
              state_r <= TDL_TOUCHED;
              cnt_r   <= 2'h0;
              secs_r  <= 8'h00; // R17
            end else if (touch_cond_i) begin
              cnt_r <= cnt_r + 2'h1;
            end else begin
              cnt_r <= 2'h0;
            end
          end
        end
        TDL_TOUCHED: begin
          if (scan_en_i && release_cond_i && rdone) begin
            state_r <= TDL_IDLE;
            cnt_r   <= 2'h0;
          end else if (sec_tick_i && timeout_i != 8'h00 && secs_r + 8'h01 >= timeout_i) begin
            state_r <= TDL_STUCK; // R8 R9
            cnt_r   <= 2'h0;
          end else begin
            if (sec_tick_i && timeout_i != 8'h00)
              secs_r <= secs_r + 8'h01; // R17
            if (scan_en_i)
              cnt_r <= release_cond_i ? cnt_r + 2'h1 : 2'h0;
          end
        end
        TDL_STUCK: begin
          // finger must leave before a new touch counts
          if (scan_en_i && release_cond_i)
            state_r <= TDL_IDLE; // R8
        end
        default: state_r <= TDL_IDLE;
      endcase
    end
  end

  assign touched_o = (state_r == TDL_TOUCHED);

  a_stuck_forces_rel: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R8
    state_r == TDL_TOUCHED && sec_tick_i && timeout_i != 8'h00 && secs_r + 8'h01 >= timeout_i
    && !(scan_en_i && release_cond_i) |=> !touched_o && state_r == TDL_STUCK)
    else $error("held touch not released at timeout");
  a_timer_off_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R9
    timeout_i == 8'h00 && $past(timeout_i) == 8'h00 |-> state_r != TDL_STUCK || $past(state_r) == TDL_STUCK)
    else $error("forced release while timer disabled");
  a_touch_immediate: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R11
    state_r == TDL_IDLE && scan_en_i && touch_cond_i && deb_cfg_i.touch_deb == 2'b00 |=> touched_o)
    else $error("immediate touch not taken");
  a_touch_debounce: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R14
    state_r == TDL_IDLE && scan_en_i && touch_cond_i && cnt_r == 2'h0 && deb_cfg_i.touch_deb != 2'b00
    |=> !touched_o)
    else $error("touch taken before debounce count");
  a_rel_immediate: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R10
    touched_o && scan_en_i && release_cond_i && deb_cfg_i.rel_deb == 2'b00 |=> !touched_o)
    else $error("immediate release not taken");
  c_stuck_seen: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) state_r == TDL_STUCK);
endmodule

// *** src/touch_decision_logic.sv ***
`timescale 1ns/1ps
`include "tdl_cfg.svh"
module touch_decision_logic
  import tdl_pkg::*;
#(
  parameter int N_BTN      = 6,
  parameter int N_WHL      = 6,
  parameter int SEC_CYCLES = `TDL_SEC_CYCLES
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      reg_wr_i,
  input  wire logic [7:0]                reg_addr_i,
  input  wire logic [7:0]                reg_wdata_i,
  input  wire logic                      scan_done_i,
  input  wire logic [N_BTN-1:0][15:0]    button_ticks_i,
  input  wire logic [N_BTN-1:0][15:0]    sensor_touch_threshold_i,
  input  wire logic [N_WHL-1:0][15:0]    wheel_ticks_i,
  input  wire logic [15:0]               wheel_pressure_i,
  input  wire logic [15:0]               wheel_position_i,
  output logic [7:0]                     reg_rd_data_o,
  output logic [N_BTN-1:0]               button_touched_o,
  output logic                           wheel_touched_o,
  output logic                           rotate_cw_o,
  output logic                           rotate_ccw_o,
  output logic [N_BTN+N_WHL-1:0]         avg_hold_o,
  output logic                           comp_req_o,
  output logic [15:0]                    wheel_norm_o
);
  localparam int NS = N_BTN + N_WHL;

  tdl_deb_cfg_s btn_deb_r;
  tdl_deb_cfg_s whl_deb_r;
  logic [7:0]   btn_avg_r;
  logic [7:0]   btn_neg_r;
  logic [7:0]   btn_ncnt_r;
  logic [7:0]   btn_hyst_r;
  logic [7:0]   btn_stuck_r;
  logic [7:0]   whl_stuck_r;
  logic [7:0]   whl_hyst_r;
  logic [15:0]  whl_norm_r;
  logic [7:0]   whl_avg_r;
  logic [7:0]   whl_neg_r;
  logic [7:0]   whl_ncnt_r;
  logic [7:0]   whl_rot_r;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      btn_deb_r   <= `TDL_RST_DEB;
      whl_deb_r   <= `TDL_RST_DEB;
      btn_avg_r   <= `TDL_RST_AVG;
      btn_neg_r   <= `TDL_RST_NEG;
      btn_ncnt_r  <= `TDL_RST_NCNT;
      btn_hyst_r  <= `TDL_RST_BTN_HYST;
      btn_stuck_r <= `TDL_RST_STUCK; // R9
      whl_stuck_r <= `TDL_RST_STUCK; // R9
      whl_hyst_r  <= `TDL_RST_WHL_HYST;
      whl_norm_r  <= `TDL_RST_NORM; // R12
      whl_avg_r   <= `TDL_RST_AVG;
      whl_neg_r   <= `TDL_RST_NEG;
      whl_ncnt_r  <= `TDL_RST_NCNT;
      whl_rot_r   <= `TDL_RST_ROT;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `TDL_OFS_BTN_DEB:     btn_deb_r   <= reg_wdata_i;
        `TDL_OFS_BTN_AVG:     btn_avg_r   <= reg_wdata_i;
        `TDL_OFS_BTN_NEG:     btn_neg_r   <= reg_wdata_i;
        `TDL_OFS_BTN_NCNT:    btn_ncnt_r  <= reg_wdata_i;
        `TDL_OFS_BTN_HYST:    btn_hyst_r  <= reg_wdata_i;
        `TDL_OFS_BTN_STUCK:   btn_stuck_r <= reg_wdata_i;
        `TDL_OFS_WHL_DEB:     whl_deb_r   <= {4'h0, reg_wdata_i[3:0]};
        `TDL_OFS_WHL_STUCK:   whl_stuck_r <= reg_wdata_i;
        `TDL_OFS_WHL_HYST:    whl_hyst_r  <= reg_wdata_i;
        `TDL_OFS_WHL_NORM_HI: whl_norm_r[15:8] <= reg_wdata_i; // R12
        `TDL_OFS_WHL_NORM_LO: whl_norm_r[7:0]  <= reg_wdata_i; // R12
        `TDL_OFS_WHL_AVG:     whl_avg_r   <= reg_wdata_i;
        `TDL_OFS_WHL_NEG:     whl_neg_r   <= reg_wdata_i;
        `TDL_OFS_WHL_NCNT:    whl_ncnt_r  <= reg_wdata_i;
        `TDL_OFS_WHL_ROT:     whl_rot_r   <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      reg_rd_data_o <= 8'h00;
    else begin
      case (reg_addr_i)
        `TDL_OFS_BTN_DEB:     reg_rd_data_o <= btn_deb_r;
        `TDL_OFS_BTN_AVG:     reg_rd_data_o <= btn_avg_r;
        `TDL_OFS_BTN_NEG:     reg_rd_data_o <= btn_neg_r;
        `TDL_OFS_BTN_NCNT:    reg_rd_data_o <= btn_ncnt_r;
        `TDL_OFS_BTN_HYST:    reg_rd_data_o <= btn_hyst_r;
        `TDL_OFS_BTN_STUCK:   reg_rd_data_o <= btn_stuck_r;
        `TDL_OFS_WHL_DEB:     reg_rd_data_o <= whl_deb_r;
        `TDL_OFS_WHL_STUCK:   reg_rd_data_o <= whl_stuck_r;
        `TDL_OFS_WHL_HYST:    reg_rd_data_o <= whl_hyst_r;
        `TDL_OFS_WHL_NORM_HI: reg_rd_data_o <= whl_norm_r[15:8];
        `TDL_OFS_WHL_NORM_LO: reg_rd_data_o <= whl_norm_r[7:0];
        `TDL_OFS_WHL_AVG:     reg_rd_data_o <= whl_avg_r;
        `TDL_OFS_WHL_NEG:     reg_rd_data_o <= whl_neg_r;
        `TDL_OFS_WHL_NCNT:    reg_rd_data_o <= whl_ncnt_r;
        `TDL_OFS_WHL_ROT:     reg_rd_data_o <= whl_rot_r;
        `TDL_OFS_STATUS:      reg_rd_data_o <= {5'h0, comp_req_o, |button_touched_o, wheel_touched_o};
        default:              reg_rd_data_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      wheel_norm_o <= `TDL_RST_NORM;
    else
      wheel_norm_o <= whl_norm_r;
  end

  // one-second tick for the forced-release timers
  logic [31:0] sec_cnt_r;
  logic        sec_tick_r;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sec_cnt_r  <= 32'h0;
      sec_tick_r <= 1'b0;
    end else begin
      sec_tick_r <= (sec_cnt_r == 32'(SEC_CYCLES - 1)); // R17
      sec_cnt_r  <= (sec_cnt_r == 32'(SEC_CYCLES - 1)) ? 32'h0 : sec_cnt_r + 32'h1;
    end
  end

  // per-sensor averaging hold and negative counters, buttons first
  logic [NS-1:0][15:0] ticks;
  logic [NS-1:0]       over_avg;
  logic [NS-1:0]       under_neg;
  logic [NS-1:0]       neg_fire;
  logic [NS-1:0][7:0]  neg_cnt_r;
  assign ticks = {wheel_ticks_i, button_ticks_i};

  for (genvar i = 0; i < NS; i++) begin : g_sens
    logic [7:0] avg_l;
    logic [7:0] neg_l;
    logic [7:0] max_l;
    assign avg_l = (i < N_BTN) ? btn_avg_r : whl_avg_r;
    assign neg_l = (i < N_BTN) ? btn_neg_r : whl_neg_r;
    // reserved code zero behaves like one
    assign max_l = ((i < N_BTN) ? btn_ncnt_r : whl_ncnt_r) | {7'h0, ~|((i < N_BTN) ? btn_ncnt_r : whl_ncnt_r)}; // R5
    assign over_avg[i]  = $signed(ticks[i]) > $signed({6'h0, avg_l, 2'b00}); // R1
    assign under_neg[i] = $signed(ticks[i]) < -$signed({6'h0, neg_l, 2'b00}); // R3
    assign neg_fire[i]  = under_neg[i] && (neg_cnt_r[i] + 8'h01 >= max_l); // R4
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
        neg_cnt_r[i] <= 8'h00;
      else if (scan_done_i)
        neg_cnt_r[i] <= (under_neg[i] && !neg_fire[i]) ? neg_cnt_r[i] + 8'h01 : 8'h00; // R4
    end
  end

  logic [$clog2(NS+1)-1:0] sat_cnt;
  always_comb begin
    sat_cnt = '0;
    for (int k = 0; k < NS; k++)
      sat_cnt = sat_cnt + {{($clog2(NS+1)-1){1'b0}}, over_avg[k]};
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avg_hold_o <= '0;
      comp_req_o <= 1'b0;
    end else begin
      comp_req_o <= 1'b0;
      if (scan_done_i) begin
        avg_hold_o <= over_avg; // R1
        comp_req_o <= (sat_cnt >= `TDL_SAT_SENSORS) || (|neg_fire); // R2 R3
      end
    end
  end

  // button hysteresis, scaled by 100 to stay in integers
  logic [N_BTN-1:0] btn_on;
  logic [N_BTN-1:0] btn_off;
  logic [N_BTN-1:0] btn_touched;
  for (genvar b = 0; b < N_BTN; b++) begin : g_btn
    logic signed [26:0] t_s;
    logic signed [26:0] thr_s;
    logic signed [26:0] up_s;
    logic signed [26:0] dn_s;
    assign t_s   = $signed({{11{button_ticks_i[b][15]}}, button_ticks_i[b]}) * `TDL_PERCENT;
    assign thr_s = $signed({11'h0, sensor_touch_threshold_i[b]});
    assign up_s  = thr_s * (`TDL_PERCENT + $signed({19'h0, btn_hyst_r}));
    assign dn_s  = thr_s * (`TDL_PERCENT - $signed({19'h0, btn_hyst_r}));
    assign btn_on[b]  = t_s > up_s; // R6
    assign btn_off[b] = t_s < dn_s; // R7
    tdl_decider u_btn (
      .sys_clk_i      (sys_clk_i),
      .reset_n_i      (reset_n_i),
      .scan_en_i      (scan_done_i),
      .sec_tick_i     (sec_tick_r),
      .touch_cond_i   (btn_on[b]),
      .release_cond_i (btn_off[b]),
      .deb_cfg_i      (btn_deb_r),
      .timeout_i      (btn_stuck_r),
      .touched_o      (btn_touched[b])
    );
  end

  // wheel status from pressure
  logic whl_on;
  logic whl_off;
  logic whl_touched;
  assign whl_on  = wheel_pressure_i > {6'h0, whl_hyst_r, 2'b00}; // R15
  assign whl_off = wheel_pressure_i == 16'h0000; // R15
  tdl_decider u_whl (
    .sys_clk_i      (sys_clk_i),
    .reset_n_i      (reset_n_i),
    .scan_en_i      (scan_done_i),
    .sec_tick_i     (sec_tick_r),
    .touch_cond_i   (whl_on),
    .release_cond_i (whl_off),
    .deb_cfg_i      (whl_deb_r),
    .timeout_i      (whl_stuck_r),
    .touched_o      (whl_touched)
  );

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      button_touched_o <= '0;
      wheel_touched_o  <= 1'b0;
    end else begin
      button_touched_o <= btn_touched;
      wheel_touched_o  <= whl_touched;
    end
  end

  // rotation: |step| * 100 > (norm / 32 * N) * percent
  // no wrap handling: a jump across the wheel seam reads as a fast rotation
  logic [15:0]        prev_pos_r;
  logic               prev_ok_r;
  logic signed [16:0] step;
  logic [16:0]        step_mag;
  logic [31:0]        step_x100;
  logic [31:0]        rot_lim;
  assign step      = $signed({1'b0, wheel_position_i}) - $signed({1'b0, prev_pos_r});
  assign step_mag  = step[16] ? 17'(-step) : 17'(step);
  assign step_x100 = {15'h0, step_mag} * 32'd100;
  assign rot_lim   = {16'h0, 16'(whl_norm_r >> `TDL_NORM_SHIFT)} * 32'(N_WHL) * {24'h0, whl_rot_r}; // R13

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_pos_r   <= 16'h0;
      prev_ok_r    <= 1'b0;
      rotate_cw_o  <= 1'b0;
      rotate_ccw_o <= 1'b0;
    end else if (scan_done_i) begin
      prev_pos_r   <= wheel_position_i;
      prev_ok_r    <= whl_touched;
      rotate_cw_o  <= whl_touched && prev_ok_r && !step[16] && step_x100 > rot_lim; // R16
      rotate_ccw_o <= whl_touched && prev_ok_r && step[16] && step_x100 > rot_lim; // R16
    end
  end

  a_avg_hold_b0: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R1
    scan_done_i && $signed(button_ticks_i[0]) > $signed({6'h0, btn_avg_r, 2'b00}) |=> avg_hold_o[0])
    else $error("averaging not held on large ticks");
  a_three_sat_comp: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R2
    scan_done_i && sat_cnt >= 3 |=> comp_req_o)
    else $error("no compensation on three saturated sensors");
  a_neg_first_fire: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R5
    scan_done_i && btn_ncnt_r == 8'h01 && under_neg[0] |=> comp_req_o)
    else $error("first negative sample did not compensate");
  a_comp_has_cause: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R4
    comp_req_o |-> $past(scan_done_i) && ($past(|neg_fire) || $past(sat_cnt) >= 3))
    else $error("compensation without cause");
  a_norm_low_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R12
    reg_wr_i && reg_addr_i == `TDL_OFS_WHL_NORM_LO |=> ##1 wheel_norm_o[7:0] == $past(reg_wdata_i, 2))
    else $error("wheel norm low byte not taken");
  a_rot_exclusive: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R16
    rotate_cw_o |-> !rotate_ccw_o && (!$past(scan_done_i) || $past(step_x100) > $past(rot_lim)))
    else $error("rotation flagged wrongly");
  a_whl_zero_rel: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R15
    whl_touched && scan_done_i && whl_off && whl_deb_r.rel_deb == 2'b00 |=> ##1 !wheel_touched_o)
    else $error("wheel not released at zero pressure");
  // sensor 0 and the first wheel sensor stand for their groups
  a_avg_hold_whl: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R1
    scan_done_i && !over_avg[N_BTN] |=> !avg_hold_o[N_BTN])
    else $error("averaging held without large ticks");
  a_btn_touch_thr: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R6
    !btn_touched[0] && !(scan_done_i && btn_on[0]) |=> !btn_touched[0])
    else $error("button touched without threshold crossing");
  a_btn_rel_thr: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R7
    scan_done_i && btn_touched[0] && btn_off[0] && btn_deb_r.rel_deb == 2'b00 |=> !btn_touched[0])
    else $error("button not released below threshold");
  a_rot_needs_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R16
    scan_done_i && !(whl_touched && prev_ok_r) |=> !rotate_cw_o && !rotate_ccw_o)
    else $error("rotation flagged without a held touch");
  a_sec_tick_pulse: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R17
    sec_tick_r |=> !sec_tick_r)
    else $error("second tick longer than one cycle");

  c_comp_sat: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) scan_done_i && sat_cnt >= 3);
  c_rot_cw: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) rotate_cw_o);
  c_btn_touch: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) $rose(button_touched_o[0]));
  c_rot_ccw: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) rotate_ccw_o);
endmodule

// *** tb/tdl_front_end.sv ***
`timescale 1ns/1ps
module tdl_front_end (
  input  wire logic        sys_clk_i,
  output logic             scan_done_o,
  output logic [5:0][15:0] button_ticks_o,
  output logic [5:0][15:0] threshold_o,
  output logic [5:0][15:0] wheel_ticks_o,
  output logic [15:0]      pressure_o,
  output logic [15:0]      position_o
);
  initial begin
    scan_done_o    = 1'b0;
    button_ticks_o = '0;
    threshold_o    = {6{16'h0064}};
    wheel_ticks_o  = '0;
    pressure_o     = 16'h0000;
    position_o     = 16'h0000;
  end

  // values only hold for the sampling edge; inverted afterwards so stale data never looks valid
  task automatic scan(input logic [5:0][15:0] bt, input logic [5:0][15:0] wt,
                      input logic [15:0] pr, input logic [15:0] ps);
    scan_done_o    = 1'b1;
    button_ticks_o = bt;
    wheel_ticks_o  = wt;
    pressure_o     = pr;
    position_o     = ps;
    @(posedge sys_clk_i);
    #1;
    scan_done_o    = 1'b0;
    button_ticks_o = ~bt;
    wheel_ticks_o  = ~wt;
    pressure_o     = ~pr;
    position_o     = ~ps;
  endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic                    sys_clk_i;
  logic                    reset_n_i;
  logic                    reg_wr_i;
  logic [7:0]              reg_addr_i;
  logic [7:0]              reg_wdata_i;
  logic [7:0]              reg_rd_data_o;
  logic                    scan_done_i;
  logic [5:0][15:0]        button_ticks_i;
  logic [5:0][15:0]        sensor_touch_threshold_i;
  logic [5:0][15:0]        wheel_ticks_i;
  logic [15:0]             wheel_pressure_i;
  logic [15:0]             wheel_position_i;
  logic [5:0]              button_touched_o;
  logic                    wheel_touched_o;
  logic                    rotate_cw_o;
  logic                    rotate_ccw_o;
  logic [11:0]             avg_hold_o;
  logic                    comp_req_o;
  logic [15:0]             wheel_norm_o;
  logic [11:0]             avg;
  logic                    comp;
  logic [1:0]              rot;
  int                      miscompares = 0;
  int                      compares = 0;
  int                      cycles = 0;
  localparam logic [15:0]  RST_TAB [16] = '{16'h2100, 16'h2250, 16'h2350, 16'h2401, 16'h250a, 16'h2600,
                                             16'h2700, 16'h2800, 16'h2903, 16'h2b01, 16'h2c40, 16'h2d50,
                                             16'h2e50, 16'h2f01, 16'h3002, 16'h4000};

  touch_decision_logic #(.N_BTN(6), .N_WHL(6), .SEC_CYCLES(20)) DUT (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .scan_done_i(scan_done_i), .button_ticks_i(button_ticks_i),
    .sensor_touch_threshold_i(sensor_touch_threshold_i), .wheel_ticks_i(wheel_ticks_i),
    .wheel_pressure_i(wheel_pressure_i), .wheel_position_i(wheel_position_i), .reg_rd_data_o(reg_rd_data_o),
    .button_touched_o(button_touched_o), .wheel_touched_o(wheel_touched_o), .rotate_cw_o(rotate_cw_o),
    .rotate_ccw_o(rotate_ccw_o), .avg_hold_o(avg_hold_o), .comp_req_o(comp_req_o), .wheel_norm_o(wheel_norm_o));

  tdl_front_end fe (
    .sys_clk_i(sys_clk_i), .scan_done_o(scan_done_i), .button_ticks_o(button_ticks_i),
    .threshold_o(sensor_touch_threshold_i), .wheel_ticks_o(wheel_ticks_i),
    .pressure_o(wheel_pressure_i), .position_o(wheel_position_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic summarize();
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // run is about 300 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge sys_clk_i);
    #1;
    reg_wr_i = 1'b0;
    // one idle edge so a following write never re-raises the strobe in this step
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    @(posedge sys_clk_i);
    #1;
    chk("register", {8'h00, exp}, {8'h00, reg_rd_data_o});
  endtask

  // flags captured one cycle after the sample, touch state one cycle later
  task automatic scan(input logic [15:0] b0, input logic [15:0] b1, input logic [15:0] w0,
                      input logic [15:0] pr, input logic [15:0] ps);
    logic [5:0][15:0] bt;
    logic [5:0][15:0] wt;
    bt = '0;
    wt = '0;
    bt[0] = b0;
    bt[1] = b1;
    wt[0] = w0;
    fe.scan(bt, wt, pr, ps);
    avg = avg_hold_o;
    comp = comp_req_o;
    rot = {rotate_cw_o, rotate_ccw_o};
    @(posedge sys_clk_i);
    #1;
  endtask

  initial begin
    reset_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    repeat (16) @(posedge sys_clk_i);
    #1;
    chk("norm_out", 16'h0140, wheel_norm_o);
    reset_n_i = 1'b1;
    foreach (RST_TAB[i]) rc(RST_TAB[i][15:8], RST_TAB[i][7:0]);
    wr(8'h27, 8'hff);
    rc(8'h27, 8'h0f);
    wr(8'h3f, 8'hff);
    rc(8'h3f, 8'h00);
    wr(8'h2b, 8'h12);
    wr(8'h2c, 8'h34);
    rc(8'h2c, 8'h34);
    chk("norm_out", 16'h1234, wheel_norm_o);
    wr(8'h2b, 8'h01);
    wr(8'h2c, 8'h40);
    wr(8'h27, 8'h00);
    scan(16'd321, 0, 16'd320, 0, 0);
    chk("avg_hold", 12'h001, avg);
    wr(8'h2d, 8'h01);
    scan(16'd320, 0, 16'd5, 0, 0);
    chk("avg_hold", 12'h040, avg);
    wr(8'h2d, 8'h50);
    scan(16'd400, 16'd400, 0, 0, 0);
    chk("comp_req", 0, comp);
    scan(16'd400, 16'd400, 16'd400, 0, 0);
    chk("comp_req", 1, comp);
    scan(16'hfec0, 0, 0, 0, 0);
    chk("comp_req", 0, comp);
    scan(16'hfebf, 0, 0, 0, 0);
    chk("comp_req", 1, comp);
    wr(8'h24, 8'h03);
    for (int k = 0; k < 3; k++) begin
      scan(16'hfebf, 0, 0, 0, 0);
      chk("comp_req", 16'(k == 2), comp);
    end
    wr(8'h24, 8'h00);
    scan(16'hfebf, 0, 0, 0, 0);
    chk("comp_req", 1, comp);
    scan(16'd110, 0, 0, 0, 0);
    chk("button_touch", 0, button_touched_o);
    scan(16'd111, 0, 0, 0, 0);
    chk("button_touch", 1, button_touched_o);
    rc(8'h3f, 8'h02);
    scan(16'd90, 0, 0, 0, 0);
    chk("button_touch", 1, button_touched_o);
    scan(16'd89, 0, 0, 0, 0);
    chk("button_touch", 0, button_touched_o);
    wr(8'h26, 8'h01);
    scan(16'd200, 0, 0, 0, 0);
    chk("button_touch", 1, button_touched_o);
    repeat (25) scan(16'd200, 0, 0, 0, 0);
    chk("button_touch", 0, button_touched_o);
    scan(0, 0, 0, 0, 0);
    // timer off before the new touch, else a second tick could race the write
    wr(8'h26, 8'h00);
    scan(16'd200, 0, 0, 0, 0);
    chk("button_touch", 1, button_touched_o);
    repeat (25) scan(16'd200, 0, 0, 0, 0);
    chk("button_touch", 1, button_touched_o);
    scan(0, 0, 0, 0, 0);
    scan(0, 0, 0, 16'd12, 0);
    chk("wheel_touch", 0, wheel_touched_o);
    for (int c = 0; c < 4; c++) begin
      wr(8'h27, 8'((c << 2) | c));
      for (int k = 0; k <= c; k++) begin
        scan(0, 0, 0, 16'd13, 0);
        chk("wheel_touch", 16'(k == c), wheel_touched_o);
      end
      for (int k = 0; k <= c; k++) begin
        scan(0, 0, 0, 0, 0);
        chk("wheel_touch", 16'(k != c), wheel_touched_o);
      end
    end
    wr(8'h27, 8'h00);
    scan(0, 0, 0, 16'd13, 16'd100);
    scan(0, 0, 0, 16'd13, 16'd100);
    scan(0, 0, 0, 16'd13, 16'd101);
    chk("rotation", 2'b00, rot);
    scan(0, 0, 0, 16'd13, 16'd103);
    chk("rotation", 2'b10, rot);
    scan(0, 0, 0, 16'd13, 16'd101);
    chk("rotation", 2'b01, rot);
    wr(8'h30, 8'h01);
    scan(0, 0, 0, 16'd13, 16'd102);
    chk("rotation", 2'b10, rot);
    scan(0, 0, 0, 0, 0);
    summarize();
  end
endmodule
